/* File: playback_cfg.svh */
`ifndef PLAYBACK_CFG_SVH
`define PLAYBACK_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Register pages and offsets
`define REG_PAGE_DIG 1'h0
`define REG_PAGE_ANA 1'h1
`define OFS_DAC_ROUTE 8'h23
`define OFS_HP_LEFT 8'h24
`define OFS_HP_RIGHT 8'h25
`define OFS_DIG_ROUTE 8'h3F

////////////////////////////////////////////////////////////////////////////
// Field positions
`define BIT_ROUTE_LEFT 6
`define BIT_ROUTE_RIGHT 2
`define BIT_AMP_EN 7
`define FLD_VOL 6:0
`define FLD_LEFT_SEL 5:4
`define FLD_RIGHT_SEL 3:2
`define FLD_STEP_SEL 1:0

////////////////////////////////////////////////////////////////////////////
// Reset values and volume codes
`define RST_DAC_ROUTE 8'h00
`define RST_HP_VOL 8'h7F
`define RST_VOL_CODE 7'h7F
`define RST_DIG_ROUTE 8'h14
`define VOL_MUTE_CODE 7'h7F
`define VOL_FLOOR_CODE 7'h75
`define ATTEN_FLOOR 10'h30F

////////////////////////////////////////////////////////////////////////////
// Timing: base soft-step interval is one 48 kHz sample period
`define CLK_PERIOD_NS 4
`define SS_BASE_NS 20833
`define SS_STEP_CYCLES (`SS_BASE_NS / `CLK_PERIOD_NS)

`endif

/* File: playback_mix.sv */
`timescale 1ns/1ps
`include "playback_cfg.svh"

module sample_fifo #(
	parameter int W = 48,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic wr, rd;

	if (DEPTH < 2 || W < 1) begin : g_bad_fifo
		$error("sample_fifo needs DEPTH of 2 or more");
	end

	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : next_ptr

	assign wr_ready = cnt_r != (AW+1)'(DEPTH);
	assign rd_valid = cnt_r != '0;
	assign rd_data = mem_r[rp_r];
	assign wr = wr_valid && wr_ready;
	assign rd = rd_valid && rd_ready;

	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (wr) begin
			mem_nxt[wp_r] = wr_data;
			wp_nxt = next_ptr(wp_r);
		end
		if (rd) begin
			rp_nxt = next_ptr(rp_r);
		end
		cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
	end

	always_ff @(posedge ref_clk) begin
		mem_r <= mem_nxt;
		if (!resetn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : sample_fifo

////////////////////////////////////////////////////////////////////////////

module playback_mix #(
	parameter int DW = 24,
	parameter int FIFO_DEPTH = 16,
	parameter int STEP_CYCLES = `SS_STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic reg_page,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [DW-1:0] in_left,
	input wire logic [DW-1:0] in_right,
	input wire logic [DW-1:0] tone_left,
	input wire logic [DW-1:0] tone_right,
	output logic dac_valid,
	input wire logic dac_ready,
	output logic [DW-1:0] dac_left,
	output logic [DW-1:0] dac_right,
	output logic vol_left_src_en,
	output logic vol_right_src_en,
	output logic hp_left_amp_en,
	output logic hp_right_amp_en,
	output logic [6:0] hp_left_code,
	output logic [6:0] hp_right_code,
	output logic [9:0] hp_left_atten,
	output logic [9:0] hp_right_atten,
	output logic hp_left_mute,
	output logic hp_right_mute
);
	localparam int CW = $clog2(STEP_CYCLES);

	if (DW < 2 || FIFO_DEPTH < 2 || STEP_CYCLES < 2) begin : g_bad_cfg
		$error("playback_mix parameters out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] route_r, route_nxt, dig_r, dig_nxt;
	logic [7:0] hpvol_r [2];
	logic [7:0] hpvol_nxt [2];
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	function automatic logic hit(input logic pg, input logic [7:0] a,
		input logic p, input logic [7:0] o);
		return pg == p && a == o;
	endfunction : hit

	always_comb begin
		route_nxt = route_r;
		dig_nxt = dig_r;
		hpvol_nxt = hpvol_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = reg_rd_en;
		if (reg_wr_en) begin
			if (hit(reg_page, reg_addr, `REG_PAGE_ANA, `OFS_DAC_ROUTE)) begin
				route_nxt = reg_wdata;
			end
			if (hit(reg_page, reg_addr, `REG_PAGE_ANA, `OFS_HP_LEFT)) begin
				hpvol_nxt[0] = reg_wdata;
			end
			if (hit(reg_page, reg_addr, `REG_PAGE_ANA, `OFS_HP_RIGHT)) begin
				hpvol_nxt[1] = reg_wdata;
			end
			if (hit(reg_page, reg_addr, `REG_PAGE_DIG, `OFS_DIG_ROUTE)) begin
				dig_nxt = reg_wdata;
			end
		end
		if (reg_rd_en) begin
			rdata_nxt = 8'h00;
			if (hit(reg_page, reg_addr, `REG_PAGE_ANA, `OFS_DAC_ROUTE)) begin
				rdata_nxt = route_r;
			end
			if (hit(reg_page, reg_addr, `REG_PAGE_ANA, `OFS_HP_LEFT)) begin
				rdata_nxt = hpvol_r[0];
			end
			if (hit(reg_page, reg_addr, `REG_PAGE_ANA, `OFS_HP_RIGHT)) begin
				rdata_nxt = hpvol_r[1];
			end
			if (hit(reg_page, reg_addr, `REG_PAGE_DIG, `OFS_DIG_ROUTE)) begin
				rdata_nxt = dig_r;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			route_r <= `RST_DAC_ROUTE;
			dig_r <= `RST_DIG_ROUTE;
			hpvol_r[0] <= `RST_HP_VOL;
			hpvol_r[1] <= `RST_HP_VOL;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			route_r <= route_nxt;
			dig_r <= dig_nxt;
			hpvol_r <= hpvol_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rd_valid = rvalid_r;
	assign vol_left_src_en = route_r[`BIT_ROUTE_LEFT];
	assign vol_right_src_en = route_r[`BIT_ROUTE_RIGHT];
	assign hp_left_amp_en = hpvol_r[0][`BIT_AMP_EN];
	assign hp_right_amp_en = hpvol_r[1][`BIT_AMP_EN];

	////////////////////////////////////////////////////////////////////////
	// Digital mixers

	logic f_valid, f_ready, take;
	logic [2*DW-1:0] f_data;
	logic [DW-1:0] f_left, f_right;
	logic [DW-1:0] dac_l_r, dac_l_nxt, dac_r_r, dac_r_nxt;
	logic dac_v_r, dac_v_nxt;
	playback_pkg::route_sel_t lsel, rsel;

	sample_fifo #(
		.W(2 * DW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.wr_valid(in_valid),
		.wr_ready(in_ready),
		.wr_data({in_left, in_right}),
		.rd_valid(f_valid),
		.rd_ready(f_ready),
		.rd_data(f_data)
	);

	// One mixer: saturating sum of the enabled inputs, a mux with one enable
	function automatic logic [DW-1:0] mix2(input logic [DW-1:0] a,
		input logic [DW-1:0] b, input logic ea, input logic eb);
		logic signed [DW:0] s;
		s = (ea ? $signed({a[DW-1], a}) : '0)
			+ (eb ? $signed({b[DW-1], b}) : '0);
		if (s[DW] != s[DW-1]) begin
			return {s[DW], {(DW-1){~s[DW]}}};
		end
		return s[DW-1:0];
	endfunction : mix2

	function automatic logic use_own(input playback_pkg::route_sel_t s);
		return s == playback_pkg::ROUTE_OWN || s == playback_pkg::ROUTE_MONO;
	endfunction : use_own

	function automatic logic use_other(input playback_pkg::route_sel_t s);
		return s == playback_pkg::ROUTE_SWAP || s == playback_pkg::ROUTE_MONO;
	endfunction : use_other

	assign lsel = playback_pkg::route_sel_t'(dig_r[`FLD_LEFT_SEL]);
	assign rsel = playback_pkg::route_sel_t'(dig_r[`FLD_RIGHT_SEL]);
	assign f_left = f_data[2*DW-1:DW];
	assign f_right = f_data[DW-1:0];
	assign f_ready = !dac_v_r || dac_ready;
	assign take = f_valid && f_ready;

	always_comb begin
		dac_v_nxt = dac_v_r && !dac_ready;
		dac_l_nxt = dac_l_r;
		dac_r_nxt = dac_r_r;
		if (take) begin
			dac_v_nxt = 1'b1;
			// First pair picks or sums playback, second pair adds tone
			dac_l_nxt = mix2(mix2(f_left, f_right, use_own(lsel),
				use_other(lsel)), tone_left, 1'b1, 1'b1);
			dac_r_nxt = mix2(mix2(f_right, f_left, use_own(rsel),
				use_other(rsel)), tone_right, 1'b1, 1'b1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dac_v_r <= 1'b0;
			dac_l_r <= '0;
			dac_r_r <= '0;
		end else begin
			dac_v_r <= dac_v_nxt;
			dac_l_r <= dac_l_nxt;
			dac_r_r <= dac_r_nxt;
		end
	end

	assign dac_valid = dac_v_r;
	assign dac_left = dac_l_r;
	assign dac_right = dac_r_r;

	////////////////////////////////////////////////////////////////////////
	// Output volume with soft-stepping

	logic [CW-1:0] div_r, div_nxt;
	logic half_r, half_nxt, tick, step_ok;
	logic [6:0] cur_r [2];
	logic [6:0] cur_nxt [2];
	logic [9:0] att_r [2];
	logic [9:0] att_nxt [2];
	playback_pkg::step_sel_t ssel;

	// Attenuation in tenths of a dB for a volume code
	function automatic logic [9:0] atten(input logic [6:0] c);
		logic [9:0] l;
		l = 10'({3'h0, c} * 10'h005);
		if (c < 7'h24) return l;
		if (c < 7'h46) return 10'(l + 10'h001);
		if (c < 7'h54) return 10'(l + 10'h002);
		case (c)
			7'h54: return 10'h1A5;
			7'h55: return 10'h1AB;
			7'h56: return 10'h1B0;
			7'h57: return 10'h1B6;
			7'h58: return 10'h1BB;
			7'h59: return 10'h1C0;
			7'h5A: return 10'h1C4;
			7'h5B: return 10'h1CA;
			7'h5C: return 10'h1CE;
			7'h5D: return 10'h1D3;
			7'h5E: return 10'h1DA;
			7'h5F: return 10'h1DF;
			7'h60: return 10'h1E2;
			7'h61: return 10'h1E7;
			7'h62: return 10'h1ED;
			7'h63: return 10'h1F4;
			7'h64: return 10'h1F7;
			7'h65: return 10'h1FE;
			7'h66: return 10'h202;
			7'h67: return 10'h206;
			7'h68: return 10'h20A;
			7'h69: return 10'h20F;
			7'h6A: return 10'h219;
			7'h6B: return 10'h21E;
			7'h6C: return 10'h229;
			7'h6D: return 10'h237;
			7'h6E: return 10'h247;
			7'h6F: return 10'h25A;
			7'h70: return 10'h273;
			7'h71: return 10'h283;
			7'h72: return 10'h296;
			7'h73: return 10'h2AF;
			7'h74: return 10'h2D2;
			default: return `ATTEN_FLOOR;
		endcase
	endfunction : atten

	assign ssel = playback_pkg::step_sel_t'(dig_r[`FLD_STEP_SEL]);
	assign tick = div_r == CW'(STEP_CYCLES - 1);

	always_comb begin
		// Free-running timebase, independent of the sample stream
		div_nxt = tick ? '0 : CW'(div_r + 1'b1);
		half_nxt = tick ? ~half_r : half_r;
		step_ok = tick && (ssel == playback_pkg::STEP_EVERY || half_r);
		for (int i = 0; i < 2; i++) begin
			cur_nxt[i] = cur_r[i];
			if (ssel[1]) begin
				cur_nxt[i] = hpvol_r[i][`FLD_VOL];
			end else if (step_ok && cur_r[i] < hpvol_r[i][`FLD_VOL]) begin
				cur_nxt[i] = 7'(cur_r[i] + 7'h01);
			end else if (step_ok && cur_r[i] > hpvol_r[i][`FLD_VOL]) begin
				cur_nxt[i] = 7'(cur_r[i] - 7'h01);
			end
			att_nxt[i] = atten(cur_nxt[i]);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			div_r <= '0;
			half_r <= 1'b0;
			cur_r[0] <= `RST_VOL_CODE;
			cur_r[1] <= `RST_VOL_CODE;
			att_r[0] <= `ATTEN_FLOOR;
			att_r[1] <= `ATTEN_FLOOR;
		end else begin
			div_r <= div_nxt;
			half_r <= half_nxt;
			cur_r <= cur_nxt;
			att_r <= att_nxt;
		end
	end

	assign hp_left_code = cur_r[0];
	assign hp_right_code = cur_r[1];
	assign hp_left_atten = att_r[0];
	assign hp_right_atten = att_r[1];
	assign hp_left_mute = !hpvol_r[0][`BIT_AMP_EN]
		&& hpvol_r[0][`FLD_VOL] == `VOL_MUTE_CODE;
	assign hp_right_mute = !hpvol_r[1][`BIT_AMP_EN]
		&& hpvol_r[1][`FLD_VOL] == `VOL_MUTE_CODE;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	AST_SWAP_LEFT: assert property (take && lsel == playback_pkg::ROUTE_SWAP
		&& tone_left == '0 |=> dac_left == $past(f_right))
		else $error("left swap did not carry right data");
	AST_TONE_ONLY: assert property (take && rsel == playback_pkg::ROUTE_OFF
		|=> dac_right == $past(tone_right))
		else $error("tone not passed alone to right");
	AST_MONO: assert property (take && lsel == playback_pkg::ROUTE_MONO
		&& rsel == playback_pkg::ROUTE_MONO && tone_left == tone_right
		|=> dac_left == dac_right)
		else $error("mono channels differ");
	AST_ROUTE_BIT: assert property (reg_wr_en && reg_page == `REG_PAGE_ANA
		&& reg_addr == `OFS_DAC_ROUTE
		|=> vol_left_src_en == $past(reg_wdata[6])
		&& vol_right_src_en == $past(reg_wdata[2]))
		else $error("route bits not applied");
	AST_AMP_EN: assert property (reg_wr_en && reg_page == `REG_PAGE_ANA
		&& reg_addr == `OFS_HP_RIGHT |=> hp_right_amp_en == $past(reg_wdata[7]))
		else $error("right amplifier enable not applied");
	AST_MUTE: assert property (reg_wr_en && reg_page == `REG_PAGE_ANA
		&& reg_addr == `OFS_HP_LEFT && reg_wdata == 8'h7F |=> hp_left_mute)
		else $error("left not muted after mute code");
	AST_STEP_ONE: assert property (!ssel[1] && !$past(ssel[1])
		|-> hp_left_code == $past(hp_left_code)
		|| hp_left_code == 7'($past(hp_left_code) + 7'h01)
		|| hp_left_code == 7'($past(hp_left_code) - 7'h01))
		else $error("volume moved more than one step");
	AST_NO_STEP: assert property (ssel[1] && hp_left_code != hpvol_r[0][6:0]
		&& !reg_wr_en |=> hp_left_code == $past(hpvol_r[0][6:0]))
		else $error("immediate volume not applied");
	AST_FLOOR: assert property (hp_left_code >= `VOL_FLOOR_CODE
		|=> hp_left_atten == `ATTEN_FLOOR || $changed(hp_left_code))
		else $error("floor codes not at lowest gain");
	AST_HALF_DB: assert property (hp_left_code == 7'h0A
		|-> hp_left_atten == 10'h032)
		else $error("half-dB step wrong");

	COV_SWAP: cover property (take && lsel == playback_pkg::ROUTE_SWAP);
	COV_RAMP: cover property (tick && hp_left_code != hpvol_r[0][6:0]);
	COV_FULL: cover property (!in_ready);
endmodule : playback_mix

/* File: playback_mix_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ev, got) begin \
	samples_checked++; \
	if ((got) !== (ev)) begin \
		errors++; \
		$display("FAIL %s expected %0h seen %0h", nm, ev, got); \
	end \
end

module playback_mix_tb_top;
	localparam int DW = 24;
	localparam int STEP = 8;
	logic ref_clk, resetn, reg_wr_en, reg_rd_en, reg_page;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_rd_valid, in_valid, in_ready, dac_valid, dac_ready;
	logic [DW-1:0] in_left, in_right, tone_left, tone_right;
	logic [DW-1:0] dac_left, dac_right;
	logic vol_left_src_en, vol_right_src_en;
	logic hp_left_amp_en, hp_right_amp_en, hp_left_mute, hp_right_mute;
	logic [6:0] hp_left_code, hp_right_code;
	logic [9:0] hp_left_atten, hp_right_atten;
	int errors;
	int samples_checked;

	playback_mix #(.DW(DW), .FIFO_DEPTH(16), .STEP_CYCLES(STEP)) uut (
		.ref_clk(ref_clk), .resetn(resetn), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_page(reg_page), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .in_valid(in_valid),
		.in_ready(in_ready), .in_left(in_left), .in_right(in_right),
		.tone_left(tone_left), .tone_right(tone_right),
		.dac_valid(dac_valid), .dac_ready(dac_ready),
		.dac_left(dac_left), .dac_right(dac_right),
		.vol_left_src_en(vol_left_src_en),
		.vol_right_src_en(vol_right_src_en),
		.hp_left_amp_en(hp_left_amp_en), .hp_right_amp_en(hp_right_amp_en),
		.hp_left_code(hp_left_code), .hp_right_code(hp_right_code),
		.hp_left_atten(hp_left_atten), .hp_right_atten(hp_right_atten),
		.hp_left_mute(hp_left_mute), .hp_right_mute(hp_right_mute)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize

	task automatic give_up();
		errors++;
		summarize();
	endtask : give_up

	task automatic reg_write(input logic p, input logic [7:0] a, d);
		@(negedge ref_clk);
		reg_wr_en = 1'b1;
		reg_page = p;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr_en = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask : reg_write

	task automatic reg_check(input logic p, input logic [7:0] a, ev);
		int n;
		@(negedge ref_clk);
		reg_rd_en = 1'b1;
		reg_page = p;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd_en = 1'b0;
		n = 0;
		while (reg_rd_valid !== 1'b1 && n < 3) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 3) give_up();
		`CHK("reg_rdata", ev, reg_rdata)
		@(negedge ref_clk);
		`CHK("rd_valid_end", 1'b0, reg_rd_valid)
		`CHK("rdata_hold", ev, reg_rdata)
	endtask : reg_check

	// Saturating sum of the selected sources plus the tone
	function automatic logic [DW-1:0] mix_exp(input logic [1:0] s,
		input logic [DW-1:0] own, oth, tone);
		logic signed [DW+1:0] v;
		v = $signed(tone);
		if (s == 2'h1 || s == 2'h3) v = v + $signed(own);
		if (s == 2'h2 || s == 2'h3) v = v + $signed(oth);
		if (v > 26'sh7FFFFF) return 24'h7FFFFF;
		if (v < -26'sh800000) return 24'h800000;
		return v[DW-1:0];
	endfunction : mix_exp

	////////////////////////////////////////////////////////////////////////
	task automatic reg_test();
		reg_check(1'h1, 8'h23, 8'h00);
		reg_check(1'h1, 8'h24, 8'h7F);
		reg_check(1'h1, 8'h25, 8'h7F);
		reg_check(1'h0, 8'h3F, 8'h14);
		`CHK("mute_l", 1'b1, hp_left_mute)
		`CHK("atten_l", 10'h30F, hp_left_atten)
		reg_write(1'h1, 8'h23, 8'h44);
		reg_write(1'h1, 8'h24, 8'hFF);
		reg_write(1'h0, 8'h23, 8'hAA);
		`CHK("src_l", 1'b1, vol_left_src_en)
		`CHK("src_r", 1'b1, vol_right_src_en)
		`CHK("amp_l", 1'b1, hp_left_amp_en)
		`CHK("mute_l", 1'b0, hp_left_mute)
		`CHK("mute_r", 1'b1, hp_right_mute)
		reg_check(1'h1, 8'h23, 8'h44);
		reg_check(1'h0, 8'h23, 8'h00);
		reg_write(1'h1, 8'h23, 8'h40);
		`CHK("src_r", 1'b0, vol_right_src_en)
		reg_write(1'h1, 8'h24, 8'h7E);
		`CHK("amp_l", 1'b0, hp_left_amp_en)
		`CHK("mute_l", 1'b0, hp_left_mute)
		reg_write(1'h1, 8'h24, 8'h7F);
		`CHK("mute_l", 1'b1, hp_left_mute)
	endtask : reg_test

	task automatic watch(input logic [6:0] tgt, input int lo, hi);
		int n;
		logic [6:0] prev;
		prev = hp_left_code;
		n = 0;
		while (hp_left_code !== tgt && n <= hi) begin
			@(negedge ref_clk);
			n++;
			if (hp_left_code !== prev) begin
				`CHK("step", 1'b1, hp_left_code - prev == 7'h1 || prev - hp_left_code == 7'h1)
				prev = hp_left_code;
			end
		end
		`CHK("step_time", 1'b1, n >= lo && n <= hi)
		if (n > hi) give_up();
	endtask : watch

	task automatic vol_test();
		logic [16:0] tbl [6];
		tbl = '{{7'h75, 10'h30F}, {7'h7F, 10'h30F}, {7'h74, 10'h2D2},
			{7'h3C, 10'h12D}, {7'h01, 10'h005}, {7'h00, 10'h000}};
		reg_write(1'h0, 8'h3F, 8'h17);
		reg_write(1'h1, 8'h24, 8'h8A);
		reg_write(1'h1, 8'h25, 8'h94);
		`CHK("code_l", 7'h0A, hp_left_code)
		`CHK("atten_l", 10'h032, hp_left_atten)
		`CHK("code_r", 7'h14, hp_right_code)
		`CHK("atten_r", 10'h064, hp_right_atten)
		`CHK("amp_r", 1'b1, hp_right_amp_en)
		reg_check(1'h1, 8'h25, 8'h94);
		for (int i = 0; i < 6; i++) begin
			reg_write(1'h1, 8'h25, {1'b1, tbl[i][16:10]});
			`CHK("atten_tbl", tbl[i][9:0], hp_right_atten)
		end
		reg_write(1'h1, 8'h24, 8'h80);
		reg_write(1'h0, 8'h3F, 8'h14);
		reg_write(1'h1, 8'h24, 8'h83);
		watch(7'h03, 2 * STEP - 3, 3 * STEP + 3);
		reg_write(1'h0, 8'h3F, 8'h15);
		reg_write(1'h1, 8'h24, 8'h80);
		watch(7'h00, 4 * STEP - 3, 6 * STEP + 3);
	endtask : vol_test

	////////////////////////////////////////////////////////////////////////
	task automatic send(input logic [DW-1:0] l, r, tl, tr,
		input logic [1:0] sl, sr);
		int n;
		@(negedge ref_clk);
		in_valid = 1'b1;
		in_left = l;
		in_right = r;
		tone_left = tl; // Tone settled before its sample enters
		tone_right = tr;
		`CHK("in_ready", 1'b1, in_ready)
		@(negedge ref_clk);
		in_valid = 1'b0;
		n = 0;
		while (dac_valid !== 1'b1 && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 10) give_up();
		`CHK("dac_left", mix_exp(sl, l, r, tl), dac_left)
		`CHK("dac_right", mix_exp(sr, r, l, tr), dac_right)
	endtask : send

	task automatic mix_test();
		logic [1:0] s;
		reg_write(1'h1, 8'h23, 8'h44);
		for (int i = 0; i < 4; i++) begin
			s = i[1:0];
			reg_write(1'h0, 8'h3F, {2'h0, s, ~s, 2'h2});
			send(24'h000100, 24'h000200, 24'h000003, 24'hFFFFFF, s, ~s);
		end
		reg_write(1'h0, 8'h3F, 8'h26);
		send(24'h000100, 24'h000200, 24'h0, 24'h0, 2'h2, 2'h1);
		reg_write(1'h0, 8'h3F, 8'h3E);
		send(24'h7FFFF0, 24'h000100, 24'h0, 24'h0, 2'h3, 2'h3);
		send(24'h800010, 24'hFFFF00, 24'h0, 24'h0, 2'h3, 2'h3);
	endtask : mix_test

	task automatic fifo_test();
		int pushed, got, n;
		reg_write(1'h0, 8'h3F, 8'h16);
		dac_ready = 1'b0;
		tone_left = '0;
		tone_right = '0;
		in_right = '0;
		pushed = 0;
		for (n = 0; n < 40; n++) begin
			@(negedge ref_clk);
			if (in_ready !== 1'b1) break;
			in_valid = 1'b1;
			in_left = pushed[DW-1:0];
			pushed++;
		end
		in_valid = 1'b0;
		dac_ready = 1'b1;
		`CHK("fill", 1'b1, pushed >= 16 && pushed <= 18)
		got = 0;
		n = 0;
		while (got < pushed && n < 80) begin
			if (dac_valid === 1'b1) begin
				`CHK("fifo_order", got[DW-1:0], dac_left)
				got++;
			end
			@(negedge ref_clk);
			n++;
		end
		if (got != pushed) give_up();
	endtask : fifo_test

	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		errors = 0;
		samples_checked = 0;
		resetn = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_page = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		in_valid = 1'b0;
		in_left = '0;
		in_right = '0;
		tone_left = '0;
		tone_right = '0;
		dac_ready = 1'b1;
		repeat (20) @(negedge ref_clk);
		resetn = 1'b1;
		reg_test();
		vol_test();
		mix_test();
		fifo_test();
		summarize();
	end
endmodule : playback_mix_tb_top

/* File: playback_pkg.sv */
package playback_pkg;

	// Playback selection of one first-stage mixer
	typedef enum logic [1:0] {
		ROUTE_OFF = 2'h0,
		ROUTE_OWN = 2'h1,
		ROUTE_SWAP = 2'h2,
		ROUTE_MONO = 2'h3
	} route_sel_t;

	// Soft-step interval selection
	typedef enum logic [1:0] {
		STEP_EVERY = 2'h0,
		STEP_EVERY_2 = 2'h1,
		STEP_NONE = 2'h2,
		STEP_NONE_ALT = 2'h3
	} step_sel_t;

endpackage : playback_pkg
